// ### shared/timer_global_params.svh
/*
 * Register offsets, field positions and reset values of the global
 * control block shared by four timer slices.
 * Assumes inclusion from the design module only.
 */
`ifndef TIMER_GLOBAL_PARAMS_SVH
`define TIMER_GLOBAL_PARAMS_SVH

`define ADDR_W              8
`define OFF_GLOBAL_CONFIG   8'h00
`define OFF_GLOBAL_STATUS   8'h04
`define OFF_GLOBAL_IDLE_SET 8'h08
`define OFF_GLOBAL_IDLE_CLR 8'h0C

`define CFG_PRESC_CLR_LSB   0
`define CFG_CLK_SEL_LSB     4
`define CFG_SUSPEND_LSB     8
`define CFG_INPUT_EN_LSB    10
`define CFG_XFER_TYPE_LSB   14
`define CFG_WRITABLE_MASK   32'h0000FF37
`define CFG_RESET           32'h00000000

`define STAT_IDLE_LSB       0
`define STAT_PRESC_RUN_BIT  8
`define IDLE_SET_STOP_BIT   8
`define IDLE_SET_ALIGN_BIT  9
`define IDLE_CLR_RUN_BIT    8

`define IDLE_RESET          4'hF
`define PRESC_RUN_RESET     1'b0

`endif

// ### shared/timer_global_pkg.sv
/*
 * Types for the global control block of the timer slices.
 * Assumes the params header is on the include path.
 */
`default_nettype none

package timer_global_pkg;
    typedef enum logic [1:0] {
        xfer_period_compare,
        xfer_with_prescaler,
        xfer_reserved,
        xfer_with_dither
    } xfer_type_t;

    typedef struct packed {
        logic period_compare;
        logic prescaler;
        logic dither;
    } xfer_kind_t;
endpackage

`default_nettype wire

// ### rtl/timer_global_ctrl.sv
/*
 * Global control and status of four timer slices: input-driven shadow
 * transfer enables and type, per-slice idle state, prescaler run state,
 * and the write-one commands that idle, stop, start or realign them.
 * Registers: configuration, status, idle-set and idle-clear words; the
 * two command words read back as zero.
 *
 * Assumes a simple register port on clk: one-cycle write and read
 * strobes, read data registered and valid in the cycle after the read,
 * no wait states. The slices and the prescaler sit outside and act on
 * slice_clk_en, the prescaler outputs and the transfer request outputs;
 * gating a slice clock leaves that slice's registers untouched.
 * Every input is synchronous to clk.
 */
// The strobed register port and the register addresses were decided locally.
// Behaviour
// - slice 1 input enable lets input request slice 1 transfers
// - slice 2 input enable lets input request slice 2 transfers
// - slice 3 input enable lets input request slice 3 transfers
// - two-bit type field picks which values an input request moves
// - type field acts only on slices whose input enable is set
// - config bits 3, 7:6 and 31:16 read zero
// - status bits 0..3 show per-slice idle, one means idle
// - idle slice has its clocks stopped
// - status bit 8 shows prescaler running
// - reserved status and idle-set bits read zero
// - writing one to idle-set bit n idles slice n
// - entering idle keeps slice register contents
// - idle-set slice bits always read zero
// - prescaler stop command clears run state, keeps registers
// - realign command clears prescaler and reloads slice values
// - realign leaves prescaler run state untouched
// - idle-clear bit n restarts slice n, reads zero
// - run-set command in idle-clear starts prescaler, reads zero
`include "timer_global_params.svh"
`default_nettype none

module timer_global_ctrl
    import timer_global_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic [`ADDR_W-1:0]  addr,
    input  wire logic [31:0]         wdata,
    input  wire logic                wr,
    input  wire logic                rd,
    output logic      [31:0]         rdata,
    input  wire logic                multichannel_xfer_request_input,
    input  wire logic [3:0]          slice_sw_xfer_request,
    output logic      [3:0]          slice_xfer_request,
    output logic      [3:0]          slice_xfer_period_compare,
    output logic      [3:0]          slice_xfer_prescaler,
    output logic      [3:0]          slice_xfer_dither,
    output logic      [3:0]          slice_clk_en,
    output logic                     prescaler_running,
    output logic                     prescaler_realign_cmd,
    output logic      [2:0]          prescaler_clear_mode,
    output logic      [1:0]          prescaler_clk_select,
    output logic      [1:0]          suspend_mode
);

    // registered state and its next value
    logic [31:0] config_q;
    logic [31:0] config_d;
    logic [3:0]  idle_q;
    logic [3:0]  idle_d;
    logic        run_q;
    logic        run_d;
    logic        realign_q;
    logic        realign_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [3:0]  xfer_req_q;
    logic [3:0]  xfer_req_d;
    logic [3:0]  xfer_pc_q;
    logic [3:0]  xfer_pc_d;
    logic [3:0]  xfer_ps_q;
    logic [3:0]  xfer_ps_d;
    logic [3:0]  xfer_di_q;
    logic [3:0]  xfer_di_d;

    // decoded strobes and fields
    logic        wr_cfg;
    logic        wr_iset;
    logic        wr_iclr;
    logic [3:0]  idle_set_bits;
    logic [3:0]  idle_clr_bits;
    logic        prescaler_stop_cmd;
    logic        prescaler_run_set_cmd;
    logic        realign_strobe;
    logic [3:0]  input_en;
    logic [3:0]  hw_req;
    xfer_type_t  xfer_type;
    xfer_kind_t  kind;

    // exact match of a register offset
    function automatic logic hit(input logic [`ADDR_W-1:0] a,
                                 input logic [`ADDR_W-1:0] off);
        return a == off;
    endfunction

    // write-one slice bits of a selected command word
    function automatic logic [3:0] slice_cmd(input logic        sel,
                                             input logic [31:0] d);
        return sel ? d[`STAT_IDLE_LSB +: 4] : 4'h0;
    endfunction

    // one command bit of a selected write
    function automatic logic cmd_bit(input logic        sel,
                                     input logic [31:0] d,
                                     input int          pos);
        return sel && d[pos];
    endfunction

    // status word: idle flags and run state, rest zero
    function automatic logic [31:0] status_word(input logic [3:0] idle,
                                                input logic       run);
        logic [31:0] w;
        w                      = 32'h00000000;
        w[`STAT_IDLE_LSB +: 4] = idle;
        w[`STAT_PRESC_RUN_BIT] = run;
        return w;
    endfunction

    function automatic xfer_kind_t kind_of(input xfer_type_t t);
        xfer_kind_t k;
        k = '0;
        unique case (t)
            xfer_period_compare: k.period_compare = 1'b1;
            xfer_with_prescaler: begin
                k.period_compare = 1'b1;
                k.prescaler      = 1'b1;
            end
            xfer_reserved:       k = '0;
            xfer_with_dither: begin
                k.period_compare = 1'b1;
                k.prescaler      = 1'b1;
                k.dither         = 1'b1;
            end
        endcase
        return k;
    endfunction

    // register selects
    assign wr_cfg  = wr && hit(addr, `OFF_GLOBAL_CONFIG);
    assign wr_iset = wr && hit(addr, `OFF_GLOBAL_IDLE_SET);
    assign wr_iclr = wr && hit(addr, `OFF_GLOBAL_IDLE_CLR);

    assign idle_set_bits         = slice_cmd(wr_iset, wdata);
    assign idle_clr_bits         = slice_cmd(wr_iclr, wdata);
    assign prescaler_stop_cmd    = cmd_bit(wr_iset, wdata,
                                           `IDLE_SET_STOP_BIT);
    assign prescaler_run_set_cmd = cmd_bit(wr_iclr, wdata,
                                           `IDLE_CLR_RUN_BIT);
    assign realign_strobe        = cmd_bit(wr_iset, wdata,
                                           `IDLE_SET_ALIGN_BIT);

    // configuration fields
    assign input_en  = config_q[`CFG_INPUT_EN_LSB +: 4];
    assign xfer_type = xfer_type_t'(config_q[`CFG_XFER_TYPE_LSB +: 2]);
    assign kind      = kind_of(xfer_type);
    assign prescaler_clear_mode = config_q[`CFG_PRESC_CLR_LSB +: 3];
    assign prescaler_clk_select = config_q[`CFG_CLK_SEL_LSB +: 2];
    assign suspend_mode         = config_q[`CFG_SUSPEND_LSB +: 2];

    always_comb begin
        config_d = config_q;
        if (wr_cfg) begin
            config_d = wdata & `CFG_WRITABLE_MASK;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            config_q <= `CFG_RESET;
        end else begin
            config_q <= config_d;
        end
    end

    // idle clear per slice
    // clear wins over set on one slice
    always_comb begin
        idle_d = idle_q;
        for (int i = 0; i < 4; i++) begin
            if (idle_clr_bits[i]) begin
                idle_d[i] = 1'b0;
            end else if (idle_set_bits[i]) begin
                idle_d[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            idle_q <= `IDLE_RESET;
        end else begin
            idle_q <= idle_d;
        end
    end

    always_comb begin
        run_d = run_q;
        if (prescaler_run_set_cmd) begin
            run_d = 1'b1;
        end else if (prescaler_stop_cmd) begin
            run_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            run_q <= `PRESC_RUN_RESET;
        end else begin
            run_q <= run_d;
        end
    end

    // realign pulse out
    // one cycle wide; counter reload happens outside
    always_comb begin
        realign_d = realign_strobe;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            realign_q <= 1'b0;
        end else begin
            realign_q <= realign_d;
        end
    end

    assign hw_req = {4{multichannel_xfer_request_input}} & input_en;

    always_comb begin
        xfer_req_d = slice_sw_xfer_request | hw_req;
    end

    // reserved type still raises the request
    always_comb begin
        xfer_pc_d = hw_req & {4{kind.period_compare}};
        xfer_ps_d = hw_req & {4{kind.prescaler}};
        xfer_di_d = hw_req & {4{kind.dither}};
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            xfer_req_q <= 4'h0;
        end else begin
            xfer_req_q <= xfer_req_d;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            xfer_pc_q <= 4'h0;
            xfer_ps_q <= 4'h0;
            xfer_di_q <= 4'h0;
        end else begin
            xfer_pc_q <= xfer_pc_d;
            xfer_ps_q <= xfer_ps_d;
            xfer_di_q <= xfer_di_d;
        end
    end

    // command bits zero
    // no wait states: data stands one cycle after rd
    always_comb begin
        rdata_d = 32'h00000000;
        if (rd) begin
            unique case (addr)
                `OFF_GLOBAL_CONFIG:   rdata_d = config_q;
                `OFF_GLOBAL_STATUS:   rdata_d = status_word(idle_q, run_q);
                `OFF_GLOBAL_IDLE_SET: rdata_d = 32'h00000000;
                `OFF_GLOBAL_IDLE_CLR: rdata_d = 32'h00000000;
                default:              rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign slice_clk_en              = ~idle_q;
    assign prescaler_running         = run_q;
    assign prescaler_realign_cmd     = realign_q;
    assign rdata                     = rdata_q;
    assign slice_xfer_request        = xfer_req_q;
    assign slice_xfer_period_compare = xfer_pc_q;
    assign slice_xfer_prescaler      = xfer_ps_q;
    assign slice_xfer_dither         = xfer_di_q;

endmodule

`default_nettype wire

// ### bench/timer_global_ctrl_properties.sv
/* assertions on the register port and idle/run outputs.
   assumes binding to timer_global_ctrl, one clock. */
`default_nettype none
module timer_global_ctrl_checker (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic [3:0]  slice_clk_en,
    input wire logic        prescaler_running,
    input wire logic        prescaler_realign_cmd
);
    timeunit 1ns;
    timeprecision 1ns;
    logic ws;
    logic wc;
    assign ws = wr && addr == 8'h08;
    assign wc = wr && addr == 8'h0C;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_idle_set: assert property (ws |=>
        (slice_clk_en & $past(wdata[3:0])) == 4'h0) else $error("set");
    a_idle_clear: assert property (wc |=>
        (~slice_clk_en & $past(wdata[3:0])) == 4'h0) else $error("clr");
    a_zero_keeps: assert property ((ws || wc) |=> ((slice_clk_en
        ^ $past(slice_clk_en)) & ~$past(wdata[3:0])) == 4'h0) else $error("z");
    a_stop_run: assert property (ws && wdata[8] |=>
        !prescaler_running) else $error("stop");
    a_run_set: assert property (wc && wdata[8] |=>
        prescaler_running) else $error("run");
    a_realign_run: assert property (ws && wdata[9] && !wdata[8] |=>
        prescaler_realign_cmd && $stable(prescaler_running)) else $error("al");
    a_cmd_read: assert property (rd && addr[3] |=>
        rdata == 32'h0) else $error("cmd rd");
    a_status_read: assert property (rd && addr == 8'h04 |=> rdata ==
        {23'h0, $past(prescaler_running), 4'h0, ~$past(slice_clk_en)})
        else $error("stat");
    c_realign: cover property (prescaler_realign_cmd);
    c_run: cover property ($rose(prescaler_running));
    c_clear: cover property (wc && wdata[0]);
endmodule
bind timer_global_ctrl timer_global_ctrl_checker checker_inst (.clk,
    .resetn, .addr, .wdata, .wr, .rd, .rdata, .slice_clk_en,
    .prescaler_running, .prescaler_realign_cmd);
`default_nettype wire

// ### bench/testbench.sv
/* self-checking bench of the global timer control block.
   assumes the design and its checker are compiled before. */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, resetn = 0, wr = 0, rd = 0, mc = 0, run, al;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  sw = 4'h0, req, pc, ps, di, en;
    logic [2:0]  clr_mode;
    logic [1:0]  clk_sel, susp;
    int          failures = 0, n_checks = 0;
    always #5 clk = ~clk;
    timer_global_ctrl timer_global_ctrl_inst (.clk, .resetn, .addr,
        .wdata, .wr, .rd, .rdata, .multichannel_xfer_request_input(mc),
        .slice_sw_xfer_request(sw), .slice_xfer_request(req),
        .slice_xfer_period_compare(pc), .slice_xfer_prescaler(ps),
        .slice_xfer_dither(di), .slice_clk_en(en), .prescaler_running(run),
        .prescaler_realign_cmd(al), .prescaler_clear_mode(clr_mode),
        .prescaler_clk_select(clk_sel), .suspend_mode(susp));
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic w(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic r(logic [7:0] a, logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", rdata, e);
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        r(8'h04, 32'h0000000F);
        w(8'h00, 32'hFFFFFFFF);
        r(8'h00, 32'h0000FF37);
        chk("clear_mode", clr_mode, 3'h7);
        chk("clk_select", clk_sel, 2'h3);
        chk("suspend", susp, 2'h3);
        w(8'h0C, 32'h0000010F);
        chk("running", run, 1'b1);
        r(8'h04, 32'h00000100);
        r(8'h0C, 32'h00000000);
        w(8'h08, 32'h00000005);
        chk("clk_en", en, 4'hA);
        r(8'h04, 32'h00000105);
        r(8'h00, 32'h0000FF37);
        r(8'h08, 32'h00000000);
        w(8'h08, 32'h00000200);
        chk("realign", al, 1'b1);
        @(posedge clk);
        #1;
        chk("realign", al, 1'b0);
        r(8'h04, 32'h00000105);
        w(8'h08, 32'h00000100);
        chk("running", run, 1'b0);
        r(8'h04, 32'h00000005);
        w(8'h0C, 32'h00000001);
        chk("clk_en", en, 4'hB);
        r(8'h04, 32'h00000004);
        w(8'h10, 32'hFFFFFFFF);
        r(8'h10, 32'h00000000);
        for (int s = 0; s < 4; s++) begin
            w(8'h00, (s << 14) | (32'h400 << s));
            @(posedge clk);
            mc <= 1'b1;
            sw <= 4'h8;
            @(posedge clk);
            mc <= 1'b0;
            sw <= 4'h0;
            #1;
            chk("req", req, 4'h8 | (4'h1 << s));
            chk("pc", pc, s == 2 ? 4'h0 : 4'h1 << s);
            chk("ps", ps, s % 2 ? 4'h1 << s : 4'h0);
            chk("di", di, s == 3 ? 4'h8 : 4'h0);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
